// *** design/slu_pkg.sv ***
// package: constants of the serial logic unit datapath
package slu_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int          WORD_W   = 12;
    localparam int          PAGE_W   = 4;
    localparam int          NPAGE    = 16;
    localparam int          NSEC     = 4;
    localparam int          RSEL_W   = 6;
    localparam int          OP_LSB   = 8;
    localparam int          MEM_BIT  = 7;
    localparam int          ACC_BIT  = 6;
    localparam logic [1:0]  CMP_FLD  = 2'h2;
    localparam int          CMP_ZBIT = 3;
    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [3:0]  TC_CODE_HI = 4'he;
    localparam logic [3:0]  TC_CODE_LO = 4'hd;
    localparam logic [3:0]  TC_DATA_HI = 4'hc;
    localparam logic [3:0]  TC_SIGN    = 4'h1;
    // ------------------------------------------------------------
    // control codes sent ahead of a word
    // ------------------------------------------------------------
    localparam logic [1:0]  CODE_READ  = 2'h3;
    localparam logic [1:0]  CODE_WRITE = 2'h2;
    // ------------------------------------------------------------
    // operation codes, instruction bits 11..8
    // ------------------------------------------------------------
    localparam logic [3:0]  OP_PAGE = 4'h0;
    localparam logic [3:0]  OP_AND  = 4'h1;
    localparam logic [3:0]  OP_INP  = 4'h2;
    localparam logic [3:0]  OP_OR   = 4'h3;
    localparam logic [3:0]  OP_XCH  = 4'h4;
    localparam logic [3:0]  OP_EQV  = 4'h5;
    localparam logic [3:0]  OP_STA  = 4'h6;
    localparam logic [3:0]  OP_SUB  = 4'h7;
    localparam logic [3:0]  OP_OUT  = 4'h8;
    localparam logic [3:0]  OP_ADD  = 4'h9;
    localparam logic [3:0]  OP_SKP  = 4'ha;
    localparam logic [3:0]  OP_NEG  = 4'hb;
    localparam logic [3:0]  OP_JMP  = 4'hc;
    localparam logic [3:0]  OP_MSK  = 4'hd;
    localparam logic [3:0]  OP_MULTIPLY_STEP_INSTR = 4'he;
    localparam logic [3:0]  OP_SKIP_DECREMENT_INSTR = 4'hf;
    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_INSTR  = 8'h00;
    localparam logic [7:0]  OFF_CTRL   = 8'h04;
    localparam logic [7:0]  OFF_STATUS = 8'h08;
    localparam logic [7:0]  OFF_ACC1   = 8'h0c;
    localparam logic [7:0]  OFF_ACC2   = 8'h10;
    localparam logic [11:0] INSTR_RST  = 12'h000;
    localparam logic [11:0] ACC_RST    = 12'h000;
    localparam logic [3:0]  PAGE_RST   = 4'h0;
    localparam logic [3:0]  CMD_A_ADDR = 4'h1;
    localparam logic [3:0]  CMD_B_ADDR = 4'h2;
endpackage : slu_pkg

// *** design/bus_switch.sv ***
// module: one-of-n two-way serial bus switch
`timescale 1ns/10ps
`default_nettype none
module bus_switch #(
    parameter int N     = 16,
    parameter int SEL_W = 4
) (
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic             fwd_en,
    input  wire logic             back_en,
    input  wire logic             fwd_bit,
    output logic      [N-1:0]     fwd,
    input  wire logic [N-1:0]     back,
    output logic                  back_bit
);
    logic [N-1:0] hot;

    // out-of-range selects decode to no lane at all
    assign hot      = N'(1) << sel;
    assign fwd      = fwd_en ? (hot & {N{fwd_bit}}) : '0;
    assign back_bit = back_en & (|(hot & back));
endmodule : bus_switch
`default_nettype wire

// *** design/minterm_adder.sv ***
// module: minterm adder with logic and mask functions
`timescale 1ns/10ps
`default_nettype none
module minterm_adder (
    input  wire logic a,
    input  wire logic b,
    input  wire logic c,
    input  wire logic logic_en,
    input  wire logic and_en,
    input  wire logic or_en,
    input  wire logic eqv_en,
    input  wire logic mask_en,
    input  wire logic mask_and,
    output logic      sum,
    output logic      cout,
    output logic      ovf
);
    logic c_t;
    logic c_f;
    logic s11;
    logic s10;
    logic s01;
    logic s00;

    // logic mode forces both carry terms high
    assign c_t  = logic_en | c;
    assign c_f  = logic_en | ~c;
    assign s11  = a & b & (logic_en ? (and_en | or_en | eqv_en) : c_t);
    assign s10  = a & ~b & (logic_en ? or_en : (c_f & ~mask_en));
    assign s01  = ~a & b & (logic_en ? or_en : c_f);
    assign s00  = ~a & ~b & (logic_en ? eqv_en : c_t);
    assign sum  = s11 | s10 | s01 | s00 | (mask_en & mask_and);
    assign cout = (a & b) | (a & c) | (b & c);
    assign ovf  = (~a & ~b & c) | (a & b & ~c);
endmodule : minterm_adder
`default_nettype wire

// *** design/serial_logic_unit.sv ***
// module: bit-serial logic unit datapath with register slave
// Operation
// - command address match zeroes switch, ORs data
// - two command decoders, own addresses, shared data
// - page instruction loads page, selects one bus
// - six-bit register select, high bits pick section
// - section zero address zero reads zero
// - register and memory switch ORed into B
// - memory bit picks memory or register switch
// - index cycle: register feeds adder, recirculates
// - listed instructions write adder into register
// - control codes sent at counts 14 and 13
// - bits 7 and 8 zero block B
// - subtract, equivalence, negate-register invert B
// - multiply step zero digit forces B zero
// - compare skip inverts other accumulator, carry one
// - A takes selected accumulator, index takes switch
// - A forced zero, ones or program counter
// - overflow strobed at sign bit from signs
// - carry cleared each word, arithmetic only
// - subtract and negate preset carry at 14
// - logic forces carry terms, picks minterms
// - mask disables half xor, adds accumulator AND
// - two 12-bit accumulators, one bit selects
`timescale 1ns/10ps
`default_nettype none
module serial_logic_unit
    import slu_pkg::*;
#(
    parameter int NREG = slu_pkg::NSEC * 16
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic      [31:0]               hrdata,
    input  wire logic                      shift_pulse,
    input  wire logic                      word_strobe,
    input  wire logic [3:0]                timing_count,
    input  wire logic [3:0]                cmd_addr_a,
    input  wire logic [3:0]                cmd_addr_b,
    input  wire logic                      cmd_data,
    input  wire logic                      prog_switch_in,
    output logic                           prog_switch_zero,
    output logic                           isr_bus,
    input  wire logic                      pc_in,
    output logic      [slu_pkg::NPAGE-1:0] mem_fwd,
    input  wire logic [slu_pkg::NPAGE-1:0] mem_back,
    output logic      [NREG-1:0]           reg_fwd,
    input  wire logic [NREG-1:0]           reg_back,
    output logic                           inhibit_register_select
);
    import slu_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0]       instr_r;
    logic              index_r;
    logic [PAGE_W-1:0] page_r;
    logic [11:0]       acc1_r;
    logic [11:0]       acc2_r;
    logic              carry_r;
    logic              ovf_r;
    logic              isr_r;
    logic [NPAGE-1:0]  mem_fwd_r;
    logic [NREG-1:0]   reg_fwd_r;
    logic              wr_pend_r;
    logic [7:0]        addr_r;
    logic [31:0]       hrdata_r;

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    logic [3:0] op;
    logic       memory_class_bit;
    logic       accumulator_select_bit;
    logic       set_data_page_instr;
    logic       store_program_counter_instr;
    logic       negate_instr;
    logic       negate_register_instr;
    logic       register_jump_instr;
    logic       skip_instr;
    logic       multiply_step_instr;
    logic       skip_decrement_instr;
    logic       mask_register_instr;
    logic       equivalence_instr;
    logic       sub_op;
    logic       cmp_skip;
    logic       cmp_zero;
    logic       arith;
    logic       logic_op;
    logic       wr_class;

    assign op                          = instr_r[11:OP_LSB];
    assign memory_class_bit            = instr_r[MEM_BIT];
    assign accumulator_select_bit      = instr_r[ACC_BIT];
    assign set_data_page_instr         = op == OP_PAGE && !memory_class_bit;
    assign store_program_counter_instr = op == OP_PAGE && memory_class_bit;
    assign negate_instr                = op == OP_NEG;
    assign negate_register_instr       = negate_instr && !memory_class_bit;
    assign register_jump_instr = op == OP_JMP && !memory_class_bit;
    assign skip_instr                  = op == OP_SKP;
    assign multiply_step_instr         = op == OP_MULTIPLY_STEP_INSTR;
    assign skip_decrement_instr        = op == OP_SKIP_DECREMENT_INSTR;
    assign mask_register_instr         = op == OP_MSK;
    assign equivalence_instr           = op == OP_EQV;
    assign sub_op                      = op == OP_SUB;
    assign cmp_skip = skip_instr && instr_r[5:4] == CMP_FLD;
    assign cmp_zero = cmp_skip && instr_r[CMP_ZBIT];
    // carry and overflow only for arithmetic results
    assign arith = op == OP_ADD || skip_instr || multiply_step_instr
                || sub_op || negate_instr || skip_decrement_instr;
    assign logic_op = op == OP_AND || op == OP_OR || equivalence_instr;
    assign wr_class = !index_r && (op == OP_XCH || op == OP_STA
                || negate_instr || store_program_counter_instr
                || skip_decrement_instr || mask_register_instr
                || op == OP_OUT);

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    logic code_cnt;
    logic data_cnt;
    logic dstep;

    assign code_cnt = timing_count == TC_CODE_HI
                   || timing_count == TC_CODE_LO;
    assign data_cnt = timing_count >= TC_SIGN
                   && timing_count <= TC_DATA_HI;
    assign dstep    = shift_pulse && data_cnt;

    // ------------------------------------------------------------
    // command override of the instruction bus
    // ------------------------------------------------------------
    logic cmd_hit;
    logic prog_sw_out;

    assign cmd_hit = cmd_addr_a == CMD_A_ADDR
                  || cmd_addr_b == CMD_B_ADDR;
    assign prog_switch_zero = cmd_hit;
    assign prog_sw_out      = cmd_hit ? 1'b0 : prog_switch_in;
    assign isr_bus          = isr_r;

    // ------------------------------------------------------------
    // memory and register switching
    // ------------------------------------------------------------
    logic mem_b;
    logic reg_b;
    logic bus;
    logic sum;
    logic code_bit;
    logic mem_bit;
    logic reg_bit;
    logic [NPAGE-1:0] mem_lanes;
    logic [NREG-1:0]  reg_lanes;
    logic [NREG-1:0]  reg_src;

    assign inhibit_register_select
        = memory_class_bit && !index_r;
    // lane zero is a constant zero, lanes one and two the accs
    assign reg_src = {reg_back[NREG-1:3], acc2_r[0], acc1_r[0],
                      1'b0};
    assign bus = mem_b | reg_b;
    assign code_bit = timing_count == TC_CODE_HI ?
        (index_r || !wr_class ? CODE_READ[1] : CODE_WRITE[1]) :
        (index_r || !wr_class ? CODE_READ[0] : CODE_WRITE[0]);
    assign mem_bit = code_cnt ? code_bit : sum;
    // the register side never sees the first code bit
    assign reg_bit = code_cnt ?
        (timing_count == TC_CODE_LO && code_bit) :
        (wr_class ? sum : reg_b);

    bus_switch #(
        .N     (NPAGE),
        .SEL_W (PAGE_W)
    ) u_mem_sw (
        .sel      (page_r),
        .fwd_en   (memory_class_bit),
        .back_en  (memory_class_bit && !index_r),
        .fwd_bit  (mem_bit),
        .fwd      (mem_lanes),
        .back     (mem_back),
        .back_bit (mem_b)
    );

    bus_switch #(
        .N     (NREG),
        .SEL_W (RSEL_W)
    ) u_reg_sw (
        .sel      (instr_r[RSEL_W-1:0]),
        .fwd_en   (!inhibit_register_select),
        .back_en  (!inhibit_register_select),
        .fwd_bit  (reg_bit),
        .fwd      (reg_lanes),
        .back     (reg_src),
        .back_bit (reg_b)
    );

    // ------------------------------------------------------------
    // adder ports
    // ------------------------------------------------------------
    logic sel_lsb;
    logic oth_lsb;
    logic b_block;
    logic b_inv;
    logic a_in;
    logic b_in;
    logic cout;
    logic ovf_cond;

    assign sel_lsb = accumulator_select_bit ? acc2_r[0] : acc1_r[0];
    assign oth_lsb = accumulator_select_bit ? acc1_r[0] : acc2_r[0];
    assign b_block = (!index_r && instr_r[8:7] == 2'h0)
                  || (multiply_step_instr && !acc2_r[0]);
    assign b_inv   = sub_op || equivalence_instr
                  || negate_register_instr;
    assign b_in = cmp_zero ? 1'b1 :
                  cmp_skip ? !oth_lsb :
                  b_inv    ? !bus :
                  b_block  ? 1'b0 : bus;
    assign a_in = index_r ? (register_jump_instr ? 1'b0
                                                 : prog_sw_out) :
                  negate_register_instr ? 1'b0 :
                  skip_decrement_instr  ? 1'b1 :
                  store_program_counter_instr ? pc_in :
                  sel_lsb;

    minterm_adder u_add (
        .a        (a_in),
        .b        (b_in),
        .c        (carry_r),
        .logic_en (logic_op),
        .and_en   (op == OP_AND),
        .or_en    (op == OP_OR),
        .eqv_en   (equivalence_instr),
        .mask_en  (mask_register_instr),
        .mask_and (acc1_r[0] & acc2_r[0]),
        .sum      (sum),
        .cout     (cout),
        .ovf      (ovf_cond)
    );

    // ------------------------------------------------------------
    // carry, overflow, page and serial outputs
    // ------------------------------------------------------------
    logic carry_nxt;
    logic acc_take;
    logic ahb_go;

    // word strobe wins: every word starts from a clear carry
    assign carry_nxt =
        word_strobe ? 1'b0 :
        (shift_pulse && timing_count == TC_CODE_HI
         && (sub_op || negate_instr || cmp_skip)) ? 1'b1 :
        (dstep && arith) ? cout : carry_r;
    assign acc_take = !index_r && !skip_instr && !wr_class
                   && op != OP_JMP;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carry_r   <= 1'b0;
            ovf_r     <= 1'b0;
            page_r    <= PAGE_RST;
            isr_r     <= 1'b0;
            mem_fwd_r <= '0;
            reg_fwd_r <= '0;
        end else begin
            carry_r <= carry_nxt;
            isr_r   <= prog_sw_out | (cmd_hit & cmd_data);
            if (dstep && arith && timing_count == TC_SIGN) begin
                ovf_r <= ovf_cond;
            end
            if (word_strobe && set_data_page_instr) begin
                page_r <= instr_r[PAGE_W-1:0];
            end
            if (shift_pulse) begin
                mem_fwd_r <= mem_lanes;
                reg_fwd_r <= reg_lanes;
            end
        end
    end

    assign mem_fwd = mem_fwd_r;
    assign reg_fwd = reg_fwd_r;

    // ------------------------------------------------------------
    // accumulators and register slave
    // ------------------------------------------------------------
    logic        w_acc1;
    logic        w_acc2;
    logic [31:0] rd_word;

    assign ahb_go    = hsel && hready && htrans[1];
    assign w_acc1    = wr_pend_r && addr_r == OFF_ACC1;
    assign w_acc2    = wr_pend_r && addr_r == OFF_ACC2;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign rd_word =
        haddr[7:0] == OFF_INSTR  ? {20'h0, instr_r} :
        haddr[7:0] == OFF_CTRL   ? {31'h0, index_r} :
        haddr[7:0] == OFF_STATUS ? {26'h0, ovf_r, carry_r, page_r} :
        haddr[7:0] == OFF_ACC1   ? {20'h0, acc1_r} :
        haddr[7:0] == OFF_ACC2   ? {20'h0, acc2_r} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h0;
            hrdata_r  <= 32'h0;
        end else begin
            wr_pend_r <= ahb_go && hwrite;
            if (ahb_go) begin
                addr_r <= haddr[7:0];
            end
            if (ahb_go && !hwrite) begin
                hrdata_r <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_r <= INSTR_RST;
            index_r <= 1'b0;
        end else if (wr_pend_r && addr_r == OFF_INSTR) begin
            instr_r <= hwdata[11:0];
        end else if (wr_pend_r && addr_r == OFF_CTRL) begin
            index_r <= hwdata[0];
        end
    end

    // lsb leaves first; the selected one takes the sum back in when acc_take is set, else recirculates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc1_r <= ACC_RST;
            acc2_r <= ACC_RST;
        end else if (w_acc1 || w_acc2) begin
            acc1_r <= w_acc1 ? hwdata[11:0] : acc1_r;
            acc2_r <= w_acc2 ? hwdata[11:0] : acc2_r;
        end else if (dstep) begin
            acc1_r <= {(acc_take && !accumulator_select_bit) ?
                       sum : acc1_r[0], acc1_r[11:1]};
            acc2_r <= {(acc_take && accumulator_select_bit) ?
                       sum : acc2_r[0], acc2_r[11:1]};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_sub_start;
        shift_pulse && !word_strobe && timing_count == TC_CODE_HI
        && (sub_op || negate_instr);
    endsequence
    sequence s_idx_code;
        shift_pulse && index_r && memory_class_bit && code_cnt;
    endsequence

    property p_cmd_override;
        cmd_hit |-> prog_switch_zero ##1 isr_bus == $past(cmd_data);
    endproperty
    a_cmd_override: assert property (p_cmd_override)
        else $error("command override not on instruction bus");

    property p_page_load;
        word_strobe && set_data_page_instr && !wr_pend_r
        |=> page_r == $past(instr_r[3:0]) [*2];
    endproperty
    a_page_load: assert property (p_page_load)
        else $error("data page not loaded");

    property p_inhibit;
        memory_class_bit && !index_r |-> inhibit_register_select
        && reg_lanes == '0;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("register switch live on memory instruction");

    property p_carry_clear;
        word_strobe |=> !carry_r;
    endproperty
    a_carry_clear: assert property (p_carry_clear)
        else $error("carry not cleared by word strobe");

    property p_carry_sub;
        s_sub_start |=> carry_r;
    endproperty
    a_carry_sub: assert property (p_carry_sub)
        else $error("carry not preset for subtraction");

    property p_ovf;
        dstep && arith && timing_count == TC_SIGN && !a_in && !b_in
        && carry_r |=> ovf_r;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow missed");

    property p_idx_code;
        s_idx_code |=> mem_fwd_r == (NPAGE'(1) << page_r);
    endproperty
    a_idx_code: assert property (p_idx_code)
        else $error("read code not sent to memory");

    property p_reg_first_code;
        shift_pulse && timing_count == TC_CODE_HI |=> reg_fwd_r == '0;
    endproperty
    a_reg_first_code: assert property (p_reg_first_code)
        else $error("first code bit reached a register");

    property p_acc_shift;
        dstep && !wr_pend_r |=> acc2_r[10:0] == $past(acc2_r[11:1]);
    endproperty
    a_acc_shift: assert property (p_acc_shift)
        else $error("accumulator did not shift right");
endmodule : serial_logic_unit
`default_nettype wire

// *** test/pool_model.sv ***
// partner: pooled memory and register modules on the serial lanes
`timescale 1ns/10ps
`default_nettype none
module pool_model (
    input  wire logic        hclk,
    input  wire logic [3:0]  timing_count,
    input  wire logic [3:0]  mem_lane,
    input  wire logic [5:0]  reg_lane,
    input  wire logic [11:0] word,
    output logic      [15:0] mem_back,
    output logic      [63:0] reg_back
);
    // --------------------------------------------------------
    // serial word source
    // --------------------------------------------------------
    logic tog = 1'b0;
    logic bit_out;
    always @(posedge hclk) tog <= ~tog;
    // code counts toggle, so a stale bit never passes for data
    assign bit_out = (timing_count >= 4'h1 && timing_count <= 4'hc)
        ? word[4'hc - timing_count] : tog;
    // other lanes carry the inverse: a wrong pick shows at once
    always_comb begin
        mem_back = {16{~bit_out}};
        reg_back = {64{~bit_out}};
        mem_back[mem_lane] = bit_out;
        reg_back[reg_lane] = bit_out;
    end
endmodule : pool_model
`default_nettype wire

// *** test/serial_logic_unit_bench.sv ***
// testbench: serial logic unit datapath
`timescale 1ns/10ps
`default_nettype none
module serial_logic_unit_bench;
    import slu_pkg::*;
    // --------------------------------------------------------
    // stimulus, partner and checks
    // --------------------------------------------------------
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic shift_pulse = 0, word_strobe = 0, cmd_data = 0;
    logic prog_switch_in = 0, prog_switch_zero, isr_bus, pc_in = 0;
    logic inhibit_register_select;
    wire  hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  timing_count = 0, cmd_addr_a = 0, cmd_addr_b = 0;
    logic [3:0]  mem_lane = 0;
    logic [5:0]  reg_lane = 0;
    logic [11:0] w = 0;
    logic [15:0] mem_fwd, mem_back;
    logic [63:0] reg_fwd, reg_back;
    int miscompares = 0, n_checks = 0, cyc = 0;
    always #2 hclk = ~hclk;
    assign hready = hreadyout;
    serial_logic_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .shift_pulse, .word_strobe, .timing_count, .cmd_addr_a,
        .cmd_addr_b, .cmd_data, .prog_switch_in, .prog_switch_zero,
        .isr_bus, .pc_in, .mem_fwd, .mem_back, .reg_fwd, .reg_back,
        .inhibit_register_select);
    pool_model u_pool (.hclk, .timing_count, .mem_lane, .reg_lane,
        .word(w), .mem_back, .reg_back);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, wr};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    // one word: strobe, two code counts, twelve data counts
    task automatic run(input logic [11:0] ins, a1, wd,
                       output logic [31:0] acc);
        logic [31:0] q;
        ahb(1, OFF_INSTR, {20'h0, ins}, q);
        ahb(1, OFF_ACC1, {20'h0, a1}, q);
        w = wd;
        word_strobe <= 1;
        @(posedge hclk);
        word_strobe <= 0;
        for (int t = 14; t >= 1; t--) begin
            {shift_pulse, timing_count} <= {1'b1, t[3:0]};
            @(posedge hclk);
        end
        shift_pulse <= 0;
        ahb(0, OFF_ACC1, 0, acc);
    endtask : run
    task automatic t_reset();
        logic [31:0] q;
        ahb(0, OFF_STATUS, 0, q);
        chk("status", 0, q);
        ahb(0, 8'h40, 0, q);
        chk("unmapped", 0, q);
        chk("hresp", 0, {31'h0, hresp});
    endtask : t_reset
    task automatic t_page_arith();
        logic [31:0] q;
        run(12'h005, 0, 0, q);
        ahb(0, OFF_STATUS, 0, q);
        chk("page", 5, {28'h0, q[3:0]});
        mem_lane <= 4'h5;
        run(12'h980, 12'h005, 12'h003, q);
        chk("add", 12'h008, q);
        chk("inhibit", 1, {31'h0, inhibit_register_select});
        run(12'h780, 12'h005, 12'h003, q);
        chk("sub", 12'h002, q);
        run(12'h980, 12'h7ff, 12'h001, q);
        chk("wrap", 12'h800, q);
        chk("mem lane", 16'h0020, mem_fwd);
        chk("reg off", 0, {31'h0, |reg_fwd});
        ahb(0, OFF_STATUS, 0, q);
        chk("ovf", 1, {31'h0, q[5]});
    endtask : t_page_arith
    task automatic t_logic();
        logic [31:0] q;
        reg_lane <= 6'h05;
        run(12'h105, 12'hf0f, 12'h0ff, q);
        chk("and", 12'h00f, q);
        run(12'h305, 12'hf0f, 12'h0ff, q);
        chk("or", 12'hfff, q);
        chk("inhibit", 0, {31'h0, inhibit_register_select});
        run(12'h205, 12'h0f0, 12'h0ff, q);
        chk("block b", 12'h0f0, q);
        run(12'hb05, 12'h7ff, 12'h001, q);
        chk("neg reg", 32'h20, reg_fwd[31:0]);
        chk("neg acc", 12'h7ff, q);
    endtask : t_logic
    // index cycle: switch feeds A, register feeds B, sum to memory
    task automatic t_index();
        logic [31:0] q;
        prog_switch_in <= 0;
        ahb(1, OFF_CTRL, 1, q);
        run(12'h985, 12'h800, 12'h800, q);
        chk("idx acc", 12'h800, q);
        chk("idx mem", 16'h0020, mem_fwd);
        chk("idx reg", 32'h20, reg_fwd[31:0]);
    endtask : t_index
    task automatic t_cmd();
        {cmd_addr_a, cmd_data} <= {CMD_A_ADDR, 1'b1};
        repeat (2) @(posedge hclk);
        chk("zero a", 1, {31'h0, prog_switch_zero});
        chk("isr a", 1, {31'h0, isr_bus});
        {cmd_addr_a, cmd_addr_b, cmd_data} <= {4'h0, CMD_B_ADDR, 1'b0};
        prog_switch_in <= 1;
        repeat (2) @(posedge hclk);
        chk("isr b", 0, {31'h0, isr_bus});
        cmd_addr_b <= 0;
        repeat (2) @(posedge hclk);
        chk("isr off", 1, {31'h0, isr_bus});
    endtask : t_cmd
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        t_reset();
        t_page_arith();
        t_logic();
        t_cmd();
        t_index();
        wrap_up();
    end
endmodule : serial_logic_unit_bench
`default_nettype wire
